/* File: bench/amb_sp_model.sv */
/*
  Scratchpad model behind the mover's byte port.
  Assumes the mover expects read data one cycle after its strobe.
*/
`timescale 1ns/100ps
`default_nettype none
module amb_sp_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] sp_addr,
  input  wire logic        sp_re,
  input  wire logic        sp_we,
  input  wire logic [7:0]  sp_wdata,
  output logic      [7:0]  sp_rdata
);
  // ------------------------------------------------
  // Register bytes and port
  // ------------------------------------------------
  logic [7:0] mem [0:65535]; // Register file, bench fills it
  initial sp_rdata = 8'h5a;
  // Data toggles when not read, so a late sample never matches
  always @(posedge clk_sys) begin
    if (sp_we) mem[sp_addr] <= sp_wdata;
    sp_rdata <= sp_re ? mem[sp_addr] : ~sp_rdata;
  end
endmodule : amb_sp_model
`default_nettype wire

/* File: bench/archive_memory_block_mover_tb_top.sv */
/*
  Self-checking bench of the block mover.
  Assumes the default mover parameters and a one-latency scratchpad.
*/
`timescale 1ns/100ps
`default_nettype none
`define SP i_amb_sp_model.mem
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  fail_count++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module archive_memory_block_mover_tb_top;
  import amb_pkg::*;
  logic clk_sys = 0, rst = 1, av_read = 0, av_write = 0, op_valid = 0;
  logic host_req = 0, host_we = 0;
  logic [3:0]  av_address = 0;
  logic [31:0] av_writedata = 0, av_readdata, rd, a;
  logic [1:0]  op_code = 0;
  logic [15:0] stack_top_level = 0, res_stack_top, sp_addr;
  logic [20:0] host_addr = 0;
  logic [7:0]  host_wdata = 0, host_rdata, sp_wdata, sp_rdata, n, hr;
  logic [7:0]  error_code_register, last_err = 0, dat [16];
  logic av_waitrequest, op_ready, res_valid, res_push, param_valid_flag;
  logic sp_re, sp_we, host_wait, host_ack;
  logic [26:0] nt, q [$]; // Notes: block, push, flag, error, top
  int fail_count = 0, checks_done = 0, seed = 19453;
  logic [15:0] kb [4] = '{AMB_KB_NONE, AMB_KB_128K, AMB_KB_512K,
                          AMB_KB_1536K};
  logic [2:0]  rcfg [4] = '{3'h1, 3'h5, 3'h2, 3'h7};
  logic [31:0] rlast [4] = '{AMB_LAST_128_DS, AMB_LAST_128_BC,
                             AMB_LAST_512, AMB_LAST_1536};
  always #20 clk_sys = ~clk_sys;
  amb_mover i_amb_mover (.clk_sys, .rst, .av_address, .av_read,
    .av_write, .av_writedata, .av_byteenable(4'hf), .av_readdata,
    .av_waitrequest, .op_valid, .op_code, .stack_top_level, .op_ready,
    .res_valid, .res_push, .res_stack_top, .param_valid_flag,
    .error_code_register, .sp_addr, .sp_re, .sp_we, .sp_wdata, .sp_rdata,
    .host_req, .host_we, .host_addr, .host_wdata, .host_wait, .host_ack,
    .host_rdata);
  amb_sp_model i_amb_sp_model (.clk_sys, .sp_addr, .sp_re, .sp_we,
    .sp_wdata, .sp_rdata);
  // ------------------------------------------------
  // Result watcher: oldest note against each result
  // ------------------------------------------------
  always @(posedge clk_sys) begin
    if (res_valid === 1'b1) begin
      nt = q.pop_front();
      `CHK("push", nt[25], res_push)
      `CHK("top", nt[15:0], res_stack_top)
      if (nt[26]) begin
        `CHK("flag", nt[24], param_valid_flag)
        `CHK("err", nt[23:16], error_code_register)
      end
    end
  end
  // ------------------------------------------------
  // Bus, operation and host tasks
  // ------------------------------------------------
  // Request held until waitrequest is seen low at an edge
  task automatic av(input logic w, input logic [3:0] ad,
                    input logic [31:0] d);
    @(posedge clk_sys);
    av_read <= !w; av_write <= w; av_address <= ad; av_writedata <= d;
    do @(posedge clk_sys); while (av_waitrequest !== 1'b0);
    rd = av_readdata;
    av_read <= 0; av_write <= 0;
  endtask : av
  task automatic op(input logic [1:0] c, input logic [15:0] b,
                    input logic [26:0] note);
    q.push_back(note);
    @(posedge clk_sys);
    op_valid <= 1; op_code <= c; stack_top_level <= b;
    do @(posedge clk_sys); while (op_ready !== 1'b1);
    op_valid <= 0;
    do @(posedge clk_sys); while (res_valid !== 1'b1);
  endtask : op
  // Parameter record: address, index, count, little endian
  task automatic rec(input logic [15:0] b, input logic [31:0] ad,
                     input logic [15:0] ix, input logic [7:0] c);
    for (int k = 0; k < 4; k++) `SP[b+k] = ad[8*k +: 8];
    {`SP[b+5], `SP[b+4], `SP[b+6]} = {ix, c};
  endtask : rec
  task automatic hst(input logic w, input logic [20:0] ad,
                     input logic [7:0] d);
    @(posedge clk_sys);
    host_req <= 1; host_we <= w; host_addr <= ad; host_wdata <= d;
    do @(posedge clk_sys); while (host_wait !== 1'b0);
    host_req <= 0;
    @(posedge clk_sys);
    `CHK("ack", 1'b1, host_ack)
    hr = host_rdata;
  endtask : hst
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    for (int f = 0; f < 4; f++) begin
      av(1, AMB_REG_CONFIG, 32'(f));
      av(0, AMB_REG_CONFIG, 0);
      `CHK("cfg", f[1:0], rd[1:0])
      op(AMB_OP_SIZE, 0, {2'b01, 9'h0, kb[f]});
    end
    $display("size test done");
    // Last good byte, then one past it, for each size and variant
    for (int e = 0; e < 4; e++) begin
      av(1, AMB_REG_CONFIG, {29'h0, rcfg[e]});
      rec(0, rlast[e], 16'd300, 8'h01);
      op(AMB_OP_READ, 0, {3'b101, last_err, 16'h0001});
      rec(0, rlast[e] + 1, 16'd300, 8'h01);
      op(AMB_OP_READ, 0, {3'b100, AMB_ERR_SRC, 16'h0});
      op(AMB_OP_WRITE, 0, {3'b100, AMB_ERR_DST, 16'h0});
      last_err = AMB_ERR_DST;
    end
    $display("range test done");
    av(1, AMB_REG_CONFIG, 32'h0000_0002);
    n = 8'(1 + ($random(seed) & 15));
    a = AMB_LAST_512 - 32'(n) + 1;
    for (int k = 0; k < 16; k++) begin
      dat[k] = 8'($random(seed));
      `SP[32+k] = dat[k];
      `SP[64+k] = ~dat[k];
    end
    rec(0, a, 16'd32, n);
    op(AMB_OP_WRITE, 0, {3'b101, last_err, 8'h0, n});
    rec(8, a, 16'd64, n);
    op(AMB_OP_READ, 8, {3'b101, last_err, 8'h0, n});
    for (int k = 0; k < 16; k++)
      `CHK("spad", (k < n) ? dat[k] : ~dat[k], `SP[64+k])
    av(0, AMB_REG_STATUS, 0);
    `CHK("moved", {n, 7'h0, 1'b1}, {rd[23:16], rd[7:1], rd[0]})
    $display("move test done");
    hst(0, a[20:0], 8'h00);
    `CHK("hostrd", dat[0], hr)
    hst(1, a[20:0], ~dat[0] ^ 8'h0f);
    rec(0, a, 16'd64, 8'h01);
    op(AMB_OP_READ, 0, {3'b101, last_err, 16'h0001});
    `CHK("hostwr", ~dat[0] ^ 8'h0f, `SP[64])
    rec(0, AMB_LAST_512 + 1, 16'd64, 8'h01);
    op(AMB_OP_READ, 0, {3'b100, AMB_ERR_SRC, 16'h0});
    `CHK("nomove", ~dat[0] ^ 8'h0f, `SP[64])
    av(0, 4'h8, 0);
    `CHK("unmap", 32'h0, rd)
    $display("host test done");
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    $display("ERROR watchdog exp finish got timeout");
    tally_and_finish;
  end
endmodule : archive_memory_block_mover_tb_top
`default_nettype wire

/* File: design/amb_mem.sv */
/*
  Byte-wide archive RAM with one port and a registered read.
  Assumes one access per cycle; the caller arbitrates.
*/
`timescale 1ns/100ps
`default_nettype none
module amb_mem #(
  parameter int AW = 21
) (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] mem [0:(1<<AW)-1]; // Battery backed, so never cleared

  // Read every cycle; data one edge after the address
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[addr];
    end
  end

endmodule : amb_mem
`default_nettype wire

/* File: design/amb_mover.sv */
/*
  Archive memory block mover: size query, block read, block write
  between archive RAM and the scratchpad, plus host channel access.
  Assumes a scratchpad with one-cycle registered read latency and a
  sequencer that keeps the result stack from the result strobe.
*/
// Contract
// - Size query pushes, returns fitted kB
// - No archive fitted: push and return zero
// - Record read in order: address, index, count
// - Read fills scratchpad, write fills archive
// - Block ops keep depth, return moved count
// - Valid flag set on good parameters only
// - Bad parameters: no data, error 14/15
// - Archive range by size and variant
// - Archive shared with serial host channel
// - 1.5 MB part valid up to 17FFFF
`timescale 1ns/100ps
`default_nettype none
module amb_mover import amb_pkg::*; #(
  parameter int          ARCH_AW     = 21,
  parameter logic [15:0] SP_LAST     = 16'hFFFF,
  parameter logic [1:0]  FIT_DEFAULT = 2'h2
) (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // Avalon-MM register slave
  input  wire logic [3:0]         av_address,
  input  wire logic               av_read,
  input  wire logic               av_write,
  input  wire logic [31:0]        av_writedata,
  input  wire logic [3:0]         av_byteenable,
  output logic      [31:0]        av_readdata,
  output logic                    av_waitrequest,
  // Sequencer operations
  input  wire logic               op_valid,
  input  wire logic [1:0]         op_code,
  input  wire logic [15:0]        stack_top_level,
  output logic                    op_ready,
  output logic                    res_valid,
  output logic                    res_push,
  output logic      [15:0]        res_stack_top,
  output logic                    param_valid_flag,
  output logic      [7:0]         error_code_register,
  // Scratchpad port
  output logic      [15:0]        sp_addr,
  output logic                    sp_re,
  output logic                    sp_we,
  output logic      [7:0]         sp_wdata,
  input  wire logic [7:0]         sp_rdata,
  // Serial host channel port
  input  wire logic               host_req,
  input  wire logic               host_we,
  input  wire logic [ARCH_AW-1:0] host_addr,
  input  wire logic [7:0]         host_wdata,
  output logic                    host_wait,
  output logic                    host_ack,
  output logic      [7:0]         host_rdata
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Block of len bytes from start stays at or below last
  function automatic logic amb_in_range(input logic [31:0] start,
                                        input logic [7:0]  len,
                                        input logic [31:0] last);
    logic [32:0] stop;
    stop = {1'b0, start} + {25'h0, len};
    amb_in_range = (len == 8'h00) || (stop <= ({1'b0, last} + 33'h1));
  endfunction : amb_in_range

  // Last archive address for fitted size and variant
  function automatic logic [31:0] amb_limit(input logic [1:0] fit,
                                            input logic       bc);
    case (fit)
      AMB_FIT_128K:  amb_limit = bc ? AMB_LAST_128_BC : AMB_LAST_128_DS;
      AMB_FIT_512K:  amb_limit = AMB_LAST_512;
      AMB_FIT_1536K: amb_limit = AMB_LAST_1536;
      default:       amb_limit = 32'h0000_0000;
    endcase
  endfunction : amb_limit

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  amb_state_t  state_r,   state_nxt;    // Sequencer
  logic        phase_r,   phase_nxt;    // Issue / complete half
  logic [2:0]  rec_r,     rec_nxt;      // Record byte position
  logic [1:0]  op_r,      op_nxt;       // Operation in progress
  logic [15:0] ptr_r,     ptr_nxt;      // Record base register
  logic [31:0] aaddr_r,   aaddr_nxt;    // archive_start_address
  logic [15:0] idx_r,     idx_nxt;      // first_register_index
  logic [7:0]  cnt_r,     cnt_nxt;      // Requested byte count
  logic [7:0]  done_r,    done_nxt;     // Bytes moved so far
  logic        valid_r,   valid_nxt;    // param_valid_flag
  logic [7:0]  err_r,     err_nxt;      // error_code_register
  logic        rv_r,      rv_nxt;       // Result strobe
  logic        rp_r,      rp_nxt;       // Result pushes
  logic [15:0] rtop_r,    rtop_nxt;     // Result for stack top
  logic        hack_r,    hack_nxt;     // Host answer strobe
  logic [1:0]  fit_r,     fit_nxt;      // Fitted size code
  logic        var_r,     var_nxt;      // Variant: 1 = B/C
  logic        avd_r,     avd_nxt;      // Avalon answer cycle
  logic [31:0] avrd_r,    avrd_nxt;     // Avalon read data

  // Memory port
  logic               mem_we;
  logic [ARCH_AW-1:0] mem_addr;
  logic [7:0]         mem_wdata;
  logic [7:0]         mem_rdata;
  logic               arch_ok, sp_ok;   // Range results
  logic               is_rd;            // Current op is a read
  logic [31:0]        arch_last;        // Last valid archive byte

  assign is_rd     = (op_r == AMB_OP_READ);
  assign arch_last = amb_limit(fit_r, var_r);
  // Nothing fitted rejects every archive block
  assign arch_ok   = (fit_r != AMB_FIT_NONE) &&
                     amb_in_range(aaddr_r, cnt_r, arch_last);
  assign sp_ok     = amb_in_range({16'h0, idx_r}, cnt_r, {16'h0, SP_LAST});

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    rec_nxt   = rec_r;
    op_nxt    = op_r;
    ptr_nxt   = ptr_r;
    aaddr_nxt = aaddr_r;
    idx_nxt   = idx_r;
    cnt_nxt   = cnt_r;
    done_nxt  = done_r;
    valid_nxt = valid_r;
    err_nxt   = err_r;
    rv_nxt    = 1'b0;
    rp_nxt    = rp_r;
    rtop_nxt  = rtop_r;
    case (state_r)
      AMB_IDLE: begin
        // Op code 3 is not an operation and is dropped
        if (op_valid && (op_code != 2'h3)) begin
          op_nxt    = op_code;
          ptr_nxt   = stack_top_level;
          rec_nxt   = 3'h0;
          phase_nxt = 1'b0;
          state_nxt = (op_code == AMB_OP_SIZE) ? AMB_DONE : AMB_FETCH;
        end
      end
      AMB_FETCH: begin
        phase_nxt = ~phase_r;
        if (phase_r) begin
          // Little endian fields: address, index, count
          if (rec_r < AMB_REC_IDX0) begin
            aaddr_nxt[rec_r[1:0]*8 +: 8] = sp_rdata;
          end else if (rec_r == AMB_REC_IDX0) begin
            idx_nxt[7:0] = sp_rdata;
          end else if (rec_r == AMB_REC_IDX1) begin
            idx_nxt[15:8] = sp_rdata;
          end else begin
            cnt_nxt = sp_rdata;
          end
          if (rec_r == AMB_REC_LAST) begin
            state_nxt = AMB_CHECK;
          end else begin
            rec_nxt = rec_r + 3'h1;
          end
        end
      end
      AMB_CHECK: begin
        done_nxt  = 8'h00;
        phase_nxt = 1'b0;
        // Source checked first, so it names the error
        if (!(is_rd ? arch_ok : sp_ok)) begin
          valid_nxt = 1'b0;
          err_nxt   = AMB_ERR_SRC;
          state_nxt = AMB_DONE;
        end else if (!(is_rd ? sp_ok : arch_ok)) begin
          valid_nxt = 1'b0;
          err_nxt   = AMB_ERR_DST;
          state_nxt = AMB_DONE;
        end else begin
          valid_nxt = 1'b1;
          state_nxt = (cnt_r == 8'h00) ? AMB_DONE : AMB_XFER;
        end
      end
      AMB_XFER: begin
        phase_nxt = ~phase_r;
        if (phase_r) begin
          done_nxt = done_r + 8'h01;
          if ((done_r + 8'h01) == cnt_r) begin
            state_nxt = AMB_DONE;
          end
        end
      end
      AMB_DONE: begin
        rv_nxt    = 1'b1;
        rp_nxt    = (op_r == AMB_OP_SIZE);
        state_nxt = AMB_IDLE;
        if (op_r == AMB_OP_SIZE) begin
          case (fit_r)
            AMB_FIT_128K:  rtop_nxt = AMB_KB_128K;
            AMB_FIT_512K:  rtop_nxt = AMB_KB_512K;
            AMB_FIT_1536K: rtop_nxt = AMB_KB_1536K;
            default:       rtop_nxt = AMB_KB_NONE;
          endcase
        end else begin
          rtop_nxt = {8'h00, done_r};
        end
      end
      default: begin
        state_nxt = AMB_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= AMB_IDLE;
      phase_r <= 1'b0;
      rec_r   <= 3'h0;
      op_r    <= AMB_OP_SIZE;
      ptr_r   <= 16'h0000;
      aaddr_r <= 32'h0000_0000;
      idx_r   <= 16'h0000;
      cnt_r   <= 8'h00;
      done_r  <= 8'h00;
      valid_r <= 1'b0;
      err_r   <= 8'h00;
      rv_r    <= 1'b0;
      rp_r    <= 1'b0;
      rtop_r  <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      rec_r   <= rec_nxt;
      op_r    <= op_nxt;
      ptr_r   <= ptr_nxt;
      aaddr_r <= aaddr_nxt;
      idx_r   <= idx_nxt;
      cnt_r   <= cnt_nxt;
      done_r  <= done_nxt;
      valid_r <= valid_nxt;
      err_r   <= err_nxt;
      rv_r    <= rv_nxt;
      rp_r    <= rp_nxt;
      rtop_r  <= rtop_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Scratchpad and archive port steering
  // ----------------------------------------------------------------
  // Host owns the RAM whenever no block is moving
  always_comb begin
    sp_re     = 1'b0;
    sp_we     = 1'b0;
    sp_addr   = idx_r + {8'h00, done_r};
    sp_wdata  = mem_rdata;
    mem_we    = 1'b0;
    mem_addr  = host_addr;
    mem_wdata = host_wdata;
    hack_nxt  = 1'b0;
    if (state_r == AMB_FETCH) begin
      sp_addr = ptr_r + {13'h0000, rec_r};
      sp_re   = ~phase_r;
    end else if (state_r == AMB_XFER) begin
      mem_addr = ARCH_AW'(aaddr_r + {24'h00_0000, done_r});
      if (is_rd) begin
        sp_we = phase_r;
      end else begin
        sp_re     = ~phase_r;
        mem_we    = phase_r;
        mem_wdata = sp_rdata;
      end
    end
    // RAM port is free outside XFER, fetch included, so the host may
    // take it there; host_wait low must always mean an accepted access
    if ((state_r != AMB_XFER) && host_req) begin
      mem_we   = host_we;
      hack_nxt = 1'b1;
    end
  end

  assign host_wait  = (state_r == AMB_XFER);
  assign host_rdata = mem_rdata;

  // Host answer register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hack_r <= 1'b0;
    end else begin
      hack_r <= hack_nxt;
    end
  end

  amb_mem #(
    .AW    (ARCH_AW)
  ) u_mem (
    .clk_sys (clk_sys),
    .rst     (rst),
    .we      (mem_we),
    .addr    (mem_addr),
    .wdata   (mem_wdata),
    .rdata   (mem_rdata)
  );

  // ----------------------------------------------------------------
  // Avalon register slave, one wait cycle per access
  // ----------------------------------------------------------------
  always_comb begin
    avd_nxt  = (av_read || av_write) && !avd_r;
    avrd_nxt = avrd_r;
    fit_nxt  = fit_r;
    var_nxt  = var_r;
    if (av_read && !avd_r) begin
      avrd_nxt = 32'h0000_0000;              // Unmapped reads zero
      if (av_address == AMB_REG_CONFIG) begin
        avrd_nxt[AMB_CFG_FIT_LSB +: 2] = fit_r;
        avrd_nxt[AMB_CFG_VAR_BIT]      = var_r;
      end else if (av_address == AMB_REG_STATUS) begin
        avrd_nxt[AMB_STS_VALID]        = valid_r;
        avrd_nxt[AMB_STS_BUSY]         = (state_r != AMB_IDLE);
        avrd_nxt[AMB_STS_ERR_LSB +: 8] = err_r;
        avrd_nxt[AMB_STS_CNT_LSB +: 8] = done_r;
      end
    end
    // Write lands at the edge where waitrequest is low
    if (av_write && avd_r && (av_address == AMB_REG_CONFIG) &&
        av_byteenable[0]) begin
      fit_nxt = av_writedata[AMB_CFG_FIT_LSB +: 2];
      var_nxt = av_writedata[AMB_CFG_VAR_BIT];
    end
  end

  // Avalon registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avd_r  <= 1'b0;
      avrd_r <= 32'h0000_0000;
      fit_r  <= FIT_DEFAULT;
      var_r  <= 1'b0;
    end else begin
      avd_r  <= avd_nxt;
      avrd_r <= avrd_nxt;
      fit_r  <= fit_nxt;
      var_r  <= var_nxt;
    end
  end

  assign av_waitrequest      = (av_read || av_write) && !avd_r;
  assign av_readdata         = avrd_r;
  assign op_ready            = (state_r == AMB_IDLE);
  assign res_valid           = rv_r;
  assign res_push            = rp_r;
  assign res_stack_top       = rtop_r;
  assign param_valid_flag    = valid_r;
  assign error_code_register = err_r;
  assign host_ack            = hack_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic take_op;
  assign take_op = op_valid && op_ready && (op_code != 2'h3);

  property p_size_push;
    take_op && (op_code == AMB_OP_SIZE) && (fit_r == AMB_FIT_512K) &&
      !av_write |-> ##2 res_valid && res_push &&
      (res_stack_top == AMB_KB_512K);
  endproperty
  a_size_push: assert property (p_size_push)
    else $error("size query result wrong");

  property p_size_none;
    take_op && (op_code == AMB_OP_SIZE) && (fit_r == AMB_FIT_NONE) &&
      !av_write |-> ##2 res_push && (res_stack_top == 16'h0000);
  endproperty
  a_size_none: assert property (p_size_none)
    else $error("empty archive size not zero");

  property p_rec_order;
    $rose(state_r == AMB_CHECK) |-> $past(rec_r) == AMB_REC_LAST;
  endproperty
  a_rec_order: assert property (p_rec_order)
    else $error("record not fully fetched");

  property p_ptr_use;
    take_op && (op_code != AMB_OP_SIZE) |->
      ##1 sp_re && (sp_addr == $past(stack_top_level));
  endproperty
  a_ptr_use: assert property (p_ptr_use)
    else $error("record base not from stack top");

  property p_copy_dir;
    (state_r == AMB_XFER) && phase_r |->
      (is_rd ? (sp_we && !mem_we && sp_wdata == mem_rdata)
             : (mem_we && !sp_we && mem_wdata == sp_rdata));
  endproperty
  a_copy_dir: assert property (p_copy_dir)
    else $error("copy direction wrong");

  property p_blk_result;
    (state_r == AMB_DONE) && (op_r != AMB_OP_SIZE) |=>
      res_valid && !res_push && (res_stack_top == {8'h00, $past(done_r)});
  endproperty
  a_blk_result: assert property (p_blk_result)
    else $error("block result not the moved count");

  property p_bad_params;
    (state_r == AMB_CHECK) && !(arch_ok && sp_ok) |=>
      !param_valid_flag && (state_r == AMB_DONE) && !sp_we &&
      (mem_we == (host_req && host_we)) &&
      ((error_code_register == AMB_ERR_SRC) ||
       (error_code_register == AMB_ERR_DST));
  endproperty
  a_bad_params: assert property (p_bad_params)
    else $error("bad parameters not rejected");

  property p_good_params;
    (state_r == AMB_CHECK) && arch_ok && sp_ok |=> param_valid_flag;
  endproperty
  a_good_params: assert property (p_good_params)
    else $error("good parameters flagged invalid");

  property p_arch_range;
    (state_r == AMB_XFER) |-> (fit_r != AMB_FIT_NONE) &&
      ({1'b0, aaddr_r} + {25'h0, done_r} <= {1'b0, arch_last});
  endproperty
  a_arch_range: assert property (p_arch_range)
    else $error("archive access beyond range");

  property p_host_share;
    host_req && (state_r != AMB_XFER) |=> host_ack;
  endproperty
  a_host_share: assert property (p_host_share)
    else $error("host access not answered");

  c_size:  cover property (take_op && (op_code == AMB_OP_SIZE));
  c_read:  cover property ((state_r == AMB_DONE) && is_rd && valid_r);
  c_write: cover property ((state_r == AMB_DONE) &&
                           (op_r == AMB_OP_WRITE) && valid_r);
  c_error: cover property ((state_r == AMB_CHECK) && !arch_ok);

endmodule : amb_mover
`default_nettype wire

/* File: design/amb_pkg.sv */
/*
  Shared constants and types of the archive memory block mover.
  Assumes a byte-wide scratchpad and a byte-wide archive memory.
*/
package amb_pkg;

  // ----------------------------------------------------------------
  // Operations from the instruction sequencer
  // ----------------------------------------------------------------
  localparam logic [1:0] AMB_OP_SIZE  = 2'h0; // archive_size_query
  localparam logic [1:0] AMB_OP_READ  = 2'h1; // archive_block_read
  localparam logic [1:0] AMB_OP_WRITE = 2'h2; // archive_block_write

  // ----------------------------------------------------------------
  // Sequencer states, Gray along idle-fetch-check-xfer-done
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AMB_IDLE  = 3'h0,
    AMB_FETCH = 3'h1,
    AMB_CHECK = 3'h3,
    AMB_XFER  = 3'h2,
    AMB_DONE  = 3'h6
  } amb_state_t;

  // ----------------------------------------------------------------
  // Fitted archive size codes, sizes in kB, last valid addresses
  // ----------------------------------------------------------------
  localparam logic [1:0]  AMB_FIT_NONE  = 2'h0;
  localparam logic [1:0]  AMB_FIT_128K  = 2'h1;
  localparam logic [1:0]  AMB_FIT_512K  = 2'h2;
  localparam logic [1:0]  AMB_FIT_1536K = 2'h3;
  localparam logic [15:0] AMB_KB_NONE   = 16'h0000;
  localparam logic [15:0] AMB_KB_128K   = 16'h0080;
  localparam logic [15:0] AMB_KB_512K   = 16'h0200;
  localparam logic [15:0] AMB_KB_1536K  = 16'h0600;
  localparam logic [31:0] AMB_LAST_128_DS = 32'h0001_FFFB;
  localparam logic [31:0] AMB_LAST_128_BC = 32'h0001_FFFF;
  localparam logic [31:0] AMB_LAST_512    = 32'h0007_FFEF;
  localparam logic [31:0] AMB_LAST_1536   = 32'h0017_FFFF;

  // ----------------------------------------------------------------
  // Error codes and parameter record layout (byte positions)
  // ----------------------------------------------------------------
  localparam logic [7:0] AMB_ERR_SRC  = 8'h14;
  localparam logic [7:0] AMB_ERR_DST  = 8'h15;
  localparam logic [2:0] AMB_REC_IDX0 = 3'h4; // first index byte
  localparam logic [2:0] AMB_REC_IDX1 = 3'h5;
  localparam logic [2:0] AMB_REC_LAST = 3'h6; // byte count byte

  // ----------------------------------------------------------------
  // Avalon register map (byte addresses) and field positions
  // ----------------------------------------------------------------
  localparam logic [3:0] AMB_REG_CONFIG = 4'h0;
  localparam logic [3:0] AMB_REG_STATUS = 4'h4;
  localparam int         AMB_CFG_FIT_LSB = 0;
  localparam int         AMB_CFG_VAR_BIT = 2;
  localparam int         AMB_STS_VALID   = 0;
  localparam int         AMB_STS_BUSY    = 1;
  localparam int         AMB_STS_ERR_LSB = 8;
  localparam int         AMB_STS_CNT_LSB = 16;

endpackage : amb_pkg
